/* rtl/adc_slots_consts.vh */
`ifndef ADC_SLOTS_CONSTS_VH
`define ADC_SLOTS_CONSTS_VH

// ----------------------------------------
// Widths and sizes
// ----------------------------------------
`define NUM_CHANNELS 8
`define CH_IDX_W 3
`define WORD_W 16
`define RAW_W 18
`define REG_NUM_W 16
`define TYPE_W 16
`define ALLOC_WORDS_W 5
`define FIFO_W 32

// ----------------------------------------
// Allocation identity: input module, eight words
// ----------------------------------------
`define IO_KIND_INPUT 2'h1
`define IO_KIND_W 2
`define EIGHT_WORD_INPUT_TYPE_WORDS 5'h08
`define LAST_CH_IDX 3'h7
`define FIRST_CH_IDX 3'h0

// ----------------------------------------
// Input-type setting words
// ----------------------------------------
`define TYPE_ADDR_BASE 16'h8018
`define TYPE_ADDR_LAST 16'h801f
`define TYPE_UNI_5V 16'h0000
`define TYPE_UNI_10V 16'h0001
`define TYPE_OFFSET_5V 16'h0002
`define TYPE_BI_5V 16'h0004
`define TYPE_BI_10V 16'h0005
`define TYPE_RESET `TYPE_BI_10V

// ----------------------------------------
// Saturation limits, signed, at 3200 codes per volt
// ----------------------------------------
`define LIM_10V_HI 18'sh07f80
`define LIM_10V_LO (-18'sh07f80)
`define LIM_5V_HI 18'sh03fff
`define LIM_5V_LO (-18'sh04000)
`define LIM_ZERO 18'sh00000

// ----------------------------------------
// Reset values and supply check
// ----------------------------------------
`define RESULT_RESET 16'h0000
`define REG_NUM_RESET 16'h0000
`define SUPPLY_SETTLE_CYCLES 2'h3
`define SUPPLY_CNT_W 2

`endif

/* rtl/word_skid_buffer.v */
`timescale 1ns/1ps
`include "adc_slots_consts.vh"

module word_skid_buffer #(
  parameter WIDTH = `FIFO_W
) (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  // Fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  // Drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  // ----------------------------------------
  // Two-entry storage
  // ----------------------------------------
  reg [WIDTH-1:0] slot [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire do_push;
  wire do_pop;

  // Full and empty come straight from the count
  assign in_ready_out = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out = slot[rd_ptr];
  assign do_push = in_valid_in && in_ready_out;
  assign do_pop = out_valid_out && out_ready_in;

  // Pointer and count update
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (do_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (do_push && !do_pop) begin
        count <= count + 2'h1;
      end else if (do_pop && !do_push) begin
        count <= count - 2'h1;
      end
    end
  end

  // Data slots hold no control state, so no reset needed
  always @(posedge core_clk_in) begin
    if (do_push) begin
      slot[wr_ptr] <= in_data_in;
    end
  end

endmodule

/* rtl/adc_result_scaling_and_slots.v */
// Functional notes
// - At allocation, report an input module needing eight 16-bit words.
// - Occupy eight contiguous host input words from the allocated base number.
// - Host batch scan fetches all results; no special command beyond scan start.
// - Channel k result goes to host word base plus k minus one.
// - Each channel's code follows its own selected range and limits.
// - Bipolar 10 V: signed 3200 per volt, minus full scale is -32000.
// - 10 V ranges clip at +32640; bipolar 10 V also clips at -32640.
// - Bipolar 5 V: 3200 per volt, clip at +16383 and -16384.
// - 0-20 mA and 0-5 V: 800 per mA, same codes, clip at 16383.
// - Missing 24 V supply at power-up raises an external supply error.
// - Per-channel input-type word selects range; reset default is bipolar 10 V.
`timescale 1ns/1ps
`include "adc_slots_consts.vh"

module adc_result_scaling_and_slots (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  // Converter sample stream
  input wire sample_valid_in,
  input wire [`CH_IDX_W-1:0] sample_ch_in,
  input wire signed [`RAW_W-1:0] sample_raw_in,
  // Input-type setting words
  input wire type_wr_in,
  input wire type_rd_in,
  input wire [`REG_NUM_W-1:0] type_addr_in,
  input wire [`TYPE_W-1:0] type_wdata_in,
  output wire [`TYPE_W-1:0] type_rdata_out,
  output wire type_rvalid_out,
  // I/O allocation
  input wire alloc_req_in,
  input wire [`REG_NUM_W-1:0] alloc_base_in,
  output wire alloc_ack_out,
  output wire [`IO_KIND_W-1:0] alloc_kind_out,
  output wire [`ALLOC_WORDS_W-1:0] alloc_words_out,
  // Batch scan
  input wire scan_start_in,
  output wire scan_busy_out,
  output wire host_input_word_valid_out,
  input wire host_input_word_ready_in,
  output wire [`WORD_W-1:0] host_input_word_out,
  output wire [`REG_NUM_W-1:0] host_input_word_num_out,
  // External supply
  input wire ext24_ok_in,
  output wire ext24_err_out,
  output wire status_ok_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  wire [`TYPE_W-1:0] input_type [0:`NUM_CHANNELS-1];
  wire [`WORD_W-1:0] result [0:`NUM_CHANNELS-1];
  reg [`REG_NUM_W-1:0] base_num;
  reg allocated;
  reg alloc_ack;
  reg [`IO_KIND_W-1:0] alloc_kind;
  reg [`ALLOC_WORDS_W-1:0] alloc_words;
  reg [`TYPE_W-1:0] type_rdata;
  reg type_rvalid;
  reg scan_state;
  reg next_scan_state;
  reg [`CH_IDX_W-1:0] scan_idx;
  reg [`CH_IDX_W-1:0] next_scan_idx;
  reg ext24_meta;
  reg ext24_sync;
  reg [`SUPPLY_CNT_W-1:0] settle_cnt;
  reg ext24_err;
  reg status_ok;
  reg [1:0] sup_state;
  wire scanning;
  wire type_hit;
  wire [`CH_IDX_W-1:0] type_sel;
  wire [`WORD_W-1:0] sample_code;
  wire buf_in_ready;
  wire buf_push;
  wire [`FIFO_W-1:0] buf_out_data;
  wire [`REG_NUM_W-1:0] scan_num;

  // ----------------------------------------
  // State codes
  // ----------------------------------------
  // Scan sequencer: idle, or walking the eight result words
  localparam SCAN_IDLE = 1'b0;
  localparam SCAN_WALK = 1'b1;
  // Supply watch: settling, watching, or latched fault
  localparam [1:0] SUP_SETTLE = 2'b00;
  localparam [1:0] SUP_WATCH = 2'b01;
  localparam [1:0] SUP_FAULT = 2'b10;

  // ----------------------------------------
  // Range scaling and saturation
  // ----------------------------------------
  // The front end delivers 0.3125 mV per code at the converter input, which is
  // already 3200 codes per volt. Current inputs go through a 250 ohm shunt, so
  // 1.25 uA per code falls out with no extra multiply; only clipping differs.
  // Clip windows per range code, in output codes:
  //   bipolar 10 V            -32640 .. +32640
  //   bipolar 5 V             -16384 .. +16383
  //   0 to 10 V                    0 .. +32640
  //   0 to 5 V and 0 to 20 mA      0 .. +16383
  //   any other code falls back to the bipolar 10 V window
  function [`WORD_W-1:0] clip_code;
    input signed [`RAW_W-1:0] raw;
    input signed [`RAW_W-1:0] hi;
    input signed [`RAW_W-1:0] lo;
    reg signed [`RAW_W-1:0] clipped;
    begin
      clipped = raw;
      if (raw > hi) begin
        clipped = hi;
      end else if (raw < lo) begin
        clipped = lo;
      end
      clip_code = clipped[`WORD_W-1:0];
    end
  endfunction

  // Pick limits from the type word of the sampled channel
  function [`WORD_W-1:0] scale_code;
    input signed [`RAW_W-1:0] raw;
    input [`TYPE_W-1:0] kind;
    begin
      case (kind)
        `TYPE_BI_10V: begin
          scale_code = clip_code(raw, `LIM_10V_HI, `LIM_10V_LO);
        end
        `TYPE_BI_5V: begin
          scale_code = clip_code(raw, `LIM_5V_HI, `LIM_5V_LO);
        end
        `TYPE_UNI_10V: begin
          scale_code = clip_code(raw, `LIM_10V_HI, `LIM_ZERO);
        end
        `TYPE_UNI_5V: begin
          scale_code = clip_code(raw, `LIM_5V_HI, `LIM_ZERO);
        end
        default: begin
          // Unsupported codes fall back to the widest, safest range
          scale_code = clip_code(raw, `LIM_10V_HI, `LIM_10V_LO);
        end
      endcase
    end
  endfunction

  assign sample_code = scale_code(sample_raw_in, input_type[sample_ch_in]);

  // ----------------------------------------
  // Input-type setting words
  // ----------------------------------------
  assign type_hit = (type_addr_in >= `TYPE_ADDR_BASE) && (type_addr_in <= `TYPE_ADDR_LAST);
  assign type_sel = type_addr_in[`CH_IDX_W-1:0];

  // One type register per channel, reset to bipolar 10 V
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CHANNELS; gi = gi + 1) begin : g_chan
      // Each channel owns its flops; the arrays above are read views only,
      // so no array element has more than one process driving it
      reg [`TYPE_W-1:0] type_word;
      reg [`WORD_W-1:0] latest_code;

      always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          type_word <= `TYPE_RESET;
        end else if (type_wr_in && type_hit && (type_sel == gi)) begin
          type_word <= type_wdata_in;
        end
      end

      // Latest code per channel; only the matching channel updates
      always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          latest_code <= `RESULT_RESET;
        end else if (sample_valid_in && (sample_ch_in == gi)) begin
          latest_code <= sample_code;
        end
      end

      assign input_type[gi] = type_word;
      assign result[gi] = latest_code;
    end
  endgenerate

  // Read-back of a type word, answered one cycle after the strobe
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      type_rdata <= `TYPE_RESET;
      type_rvalid <= 1'b0;
    end else begin
      type_rvalid <= type_rd_in && type_hit;
      if (type_rd_in && type_hit) begin
        type_rdata <= input_type[type_sel];
      end
    end
  end

  assign type_rdata_out = type_rdata;
  assign type_rvalid_out = type_rvalid;

  // ----------------------------------------
  // I/O allocation
  // ----------------------------------------
  // The base number is the first of the eight words; a new allocation
  // simply replaces it, even during a scan, so reallocate only when idle.
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      base_num <= `REG_NUM_RESET;
      allocated <= 1'b0;
      alloc_ack <= 1'b0;
      alloc_kind <= `IO_KIND_INPUT;
      alloc_words <= `EIGHT_WORD_INPUT_TYPE_WORDS;
    end else begin
      alloc_ack <= alloc_req_in;
      if (alloc_req_in) begin
        base_num <= alloc_base_in;
        allocated <= 1'b1;
        alloc_kind <= `IO_KIND_INPUT;
        alloc_words <= `EIGHT_WORD_INPUT_TYPE_WORDS;
      end
    end
  end

  assign alloc_ack_out = alloc_ack;
  assign alloc_kind_out = alloc_kind;
  assign alloc_words_out = alloc_words;

  // ----------------------------------------
  // Batch scan sequencer
  // ----------------------------------------
  // Walks the eight results in channel order into the buffer. When the host
  // stalls, the buffer fills and the walk waits, so no word is dropped.
  assign scanning = (scan_state == SCAN_WALK);
  assign buf_push = scanning;
  assign scan_num = base_num + {{(`REG_NUM_W-`CH_IDX_W){1'b0}}, scan_idx};

  // Next state; a start is only looked at while idle
  always @* begin
    next_scan_state = scan_state;
    next_scan_idx = scan_idx;
    case (scan_state)
      SCAN_IDLE: begin
        // A start before allocation has no slot to fill and is ignored
        if (scan_start_in && allocated) begin
          next_scan_state = SCAN_WALK;
          next_scan_idx = `FIRST_CH_IDX;
        end
      end
      SCAN_WALK: begin
        // Advance only on an accepted push, so a stall holds the index
        if (buf_in_ready) begin
          if (scan_idx == `LAST_CH_IDX) begin
            next_scan_state = SCAN_IDLE;
          end else begin
            next_scan_idx = scan_idx + 3'h1;
          end
        end
      end
      default: begin
        next_scan_state = SCAN_IDLE;
      end
    endcase
  end

  // Sequencer state and index
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scan_state <= SCAN_IDLE;
      scan_idx <= `FIRST_CH_IDX;
    end else begin
      scan_state <= next_scan_state;
      scan_idx <= next_scan_idx;
    end
  end

  // Buffer entry carries the word number and the result word
  word_skid_buffer #(
    .WIDTH(`FIFO_W)
  ) u_buf (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .in_valid_in(buf_push),
    .in_ready_out(buf_in_ready),
    .in_data_in({scan_num, result[scan_idx]}),
    .out_valid_out(host_input_word_valid_out),
    .out_ready_in(host_input_word_ready_in),
    .out_data_out(buf_out_data)
  );

  // Number fixed at push time, so both outputs come straight from buffer flops
  assign host_input_word_out = buf_out_data[`WORD_W-1:0];
  assign host_input_word_num_out = buf_out_data[`FIFO_W-1:`WORD_W];
  assign scan_busy_out = scanning || host_input_word_valid_out;

  // ----------------------------------------
  // External 24 V supply watch
  // ----------------------------------------
  // Pin passes two flops before anything looks at it
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext24_meta <= 1'b0;
      ext24_sync <= 1'b0;
    end else begin
      ext24_meta <= ext24_ok_in;
      ext24_sync <= ext24_meta;
    end
  end

  // Wait for the synchroniser to fill before judging the supply
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      settle_cnt <= {`SUPPLY_CNT_W{1'b0}};
    end else if (settle_cnt != `SUPPLY_SETTLE_CYCLES) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end

  // Settle, then watch; a fault is sticky until reset
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sup_state <= SUP_SETTLE;
      ext24_err <= 1'b0;
      status_ok <= 1'b1;
    end else begin
      case (sup_state)
        SUP_SETTLE: begin
          // Judging earlier would see the synchroniser's reset level
          if (settle_cnt == `SUPPLY_SETTLE_CYCLES) begin
            if (ext24_sync) begin
              sup_state <= SUP_WATCH;
            end else begin
              sup_state <= SUP_FAULT;
              ext24_err <= 1'b1;
              status_ok <= 1'b0;
            end
          end
        end
        SUP_WATCH: begin
          // A later drop is flagged the same way
          if (!ext24_sync) begin
            sup_state <= SUP_FAULT;
            ext24_err <= 1'b1;
            status_ok <= 1'b0;
          end
        end
        SUP_FAULT: begin
          ext24_err <= 1'b1;
          status_ok <= 1'b0;
        end
        default: begin
          sup_state <= SUP_FAULT;
          ext24_err <= 1'b1;
          status_ok <= 1'b0;
        end
      endcase
    end
  end

  assign ext24_err_out = ext24_err;
  assign status_ok_out = status_ok;

endmodule

/* test/adc_slots_checker.sv */
`timescale 1ns/1ps
`include "adc_slots_consts.vh"
module adc_slots_checker (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  // Allocation and type words
  input wire alloc_req_in,
  input wire [15:0] alloc_base_in,
  input wire alloc_ack_out,
  input wire [1:0] alloc_kind_out,
  input wire [4:0] alloc_words_out,
  input wire type_rd_in,
  input wire [15:0] type_addr_in,
  input wire type_rvalid_out,
  // Batch scan and supply
  input wire scan_start_in,
  input wire scan_busy_out,
  input wire host_input_word_valid_out,
  input wire host_input_word_ready_in,
  input wire [15:0] host_input_word_out,
  input wire [15:0] host_input_word_num_out,
  input wire ext24_err_out
);
  reg [15:0] base;
  reg alloc_seen;
  wire type_hit = type_addr_in >= `TYPE_ADDR_BASE && type_addr_in <= `TYPE_ADDR_LAST;
  // Own copy of the base, so word numbers are judged against the host's choice
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      base <= 16'h0000;
      alloc_seen <= 1'b0;
    end else if (alloc_req_in) begin
      base <= alloc_base_in;
      alloc_seen <= 1'b1;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Busy low means sequencer idle and buffer empty, so the start is taken
  sequence scan_go;
    scan_start_in && !scan_busy_out && alloc_seen;
  endsequence
  sequence first_word;
    ##2 host_input_word_valid_out && host_input_word_num_out == base;
  endsequence
  AST_ALLOC_ACK: assert property (alloc_req_in |=> alloc_ack_out)
    else $error("allocation not acknowledged");
  AST_ALLOC_ID: assert property (alloc_ack_out |->
    alloc_kind_out == `IO_KIND_INPUT && alloc_words_out == `EIGHT_WORD_INPUT_TYPE_WORDS)
    else $error("wrong allocation identity");
  AST_SCAN_FIRST: assert property (scan_go |-> first_word)
    else $error("first scan word late or misnumbered");
  AST_WORD_HOLD: assert property (host_input_word_valid_out && !host_input_word_ready_in |=>
    host_input_word_valid_out && $stable(host_input_word_out) && $stable(host_input_word_num_out))
    else $error("offered word dropped while host stalls");
  AST_NUM_RANGE: assert property (host_input_word_valid_out |->
    16'(host_input_word_num_out - base) < 16'h0008)
    else $error("word number outside the eight slots");
  AST_WORD_LIMIT: assert property (host_input_word_valid_out |->
    $signed(host_input_word_out) >= 16'sh8080 && $signed(host_input_word_out) <= 16'sh7f80)
    else $error("word beyond saturation limits");
  AST_RVALID_CAUSE: assert property (type_rvalid_out |-> $past(type_rd_in) && $past(type_hit))
    else $error("read answer without valid read");
  AST_ERR_STICKY: assert property (ext24_err_out |=> ext24_err_out)
    else $error("supply error cleared without reset");
endmodule

bind adc_result_scaling_and_slots adc_slots_checker chk (.core_clk_in, .rst_in, .alloc_req_in,
  .alloc_base_in, .alloc_ack_out, .alloc_kind_out, .alloc_words_out, .type_rd_in, .type_addr_in,
  .type_rvalid_out, .scan_start_in, .scan_busy_out, .host_input_word_valid_out,
  .host_input_word_ready_in, .host_input_word_out, .host_input_word_num_out, .ext24_err_out);

/* test/host_scan_model.sv */
`timescale 1ns/1ps
module host_scan_model (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  // Word stream from the module
  input wire valid_in,
  input wire [15:0] word_in,
  input wire [15:0] num_in,
  output reg ready_out,
  // Bench control: stall makes the host slow
  input wire stall_in
);
  logic [15:0] words [0:7];
  logic [15:0] nums [0:7];
  int got;
  // Batch scan: every accepted word lands in the next slot
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      got <= 0;
      ready_out <= 1'b0;
    end else begin
      ready_out <= !stall_in;
      if (valid_in && ready_out) begin
        words[got[2:0]] <= word_in;
        nums[got[2:0]] <= num_in;
        got <= got + 1;
      end
    end
  end
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
`include "adc_slots_consts.vh"
module testbench;
  logic core_clk_in, rst_in, sample_valid_in, type_wr_in, type_rd_in;
  logic alloc_req_in, scan_start_in, ext24_ok_in, stall;
  logic [2:0] sample_ch_in;
  logic signed [17:0] sample_raw_in;
  logic [15:0] type_addr_in, type_wdata_in, alloc_base_in;
  wire [15:0] type_rdata_out, host_input_word_out, host_input_word_num_out;
  wire [1:0] alloc_kind_out;
  wire [4:0] alloc_words_out;
  wire type_rvalid_out, alloc_ack_out, scan_busy_out, host_input_word_valid_out;
  wire host_input_word_ready_in, ext24_err_out, status_ok_out;
  int fails, checks_done, cycles, i;
  logic [15:0] exp_word [0:7];
  logic [15:0] type_tab [0:7];
  logic signed [17:0] raw_tab [0:7];

  adc_result_scaling_and_slots dut (.core_clk_in, .rst_in, .sample_valid_in, .sample_ch_in,
    .sample_raw_in, .type_wr_in, .type_rd_in, .type_addr_in, .type_wdata_in, .type_rdata_out,
    .type_rvalid_out, .alloc_req_in, .alloc_base_in, .alloc_ack_out, .alloc_kind_out,
    .alloc_words_out, .scan_start_in, .scan_busy_out, .host_input_word_valid_out,
    .host_input_word_ready_in, .host_input_word_out, .host_input_word_num_out, .ext24_ok_in,
    .ext24_err_out, .status_ok_out);
  host_scan_model host (.core_clk_in, .rst_in, .valid_in(host_input_word_valid_out),
    .word_in(host_input_word_out), .num_in(host_input_word_num_out),
    .ready_out(host_input_word_ready_in), .stall_in(stall));

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle strobe; returns just after the edge that took it
  task automatic type_acc(input logic wr, input logic [15:0] addr, input logic [15:0] d);
    @(posedge core_clk_in);
    type_wr_in <= wr;
    type_rd_in <= !wr;
    type_addr_in <= addr;
    type_wdata_in <= d;
    @(posedge core_clk_in);
    type_wr_in <= 1'b0;
    type_rd_in <= 1'b0;
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Clock
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // Hang guard, well above the hundred or so cycles the run needs
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test;
    end
  end

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    {rst_in, ext24_ok_in, stall} = 3'h6;
    {sample_valid_in, type_wr_in, type_rd_in, alloc_req_in, scan_start_in} = 5'h00;
    sample_ch_in = 3'h0;
    sample_raw_in = 18'sh00000;
    type_addr_in = 16'h0000;
    type_wdata_in = 16'h0000;
    alloc_base_in = 16'h0000;
    fails = 0;
    checks_done = 0;
    cycles = 0;
    type_tab = '{16'h0005, 16'h0005, 16'h0004, 16'h0004, 16'h0001, 16'h0000, 16'h0001, 16'h0005};
    raw_tab = '{18'sh09c40, -18'sh07d00, 18'sh04e20, -18'sh04e20, -18'sh00005, 18'sh03e80,
      18'sh09c40, -18'sh09c40};
    exp_word = '{16'h7f80, 16'h8300, 16'h3fff, 16'hc000, 16'h0000, 16'h3e80, 16'h7f80, 16'h8080};
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    // Defaults, then each channel gets its own range
    for (i = 0; i < 8; i++) begin
      type_acc(1'b0, `TYPE_ADDR_BASE + 16'(i), 16'h0000);
      cmp({15'h0000, type_rvalid_out}, 16'h0001);
      cmp(type_rdata_out, `TYPE_BI_10V);
      type_acc(1'b1, `TYPE_ADDR_BASE + 16'(i), type_tab[i]);
    end
    type_acc(1'b0, 16'h8020, 16'h0000);
    cmp({15'h0000, type_rvalid_out}, 16'h0000);
    type_acc(1'b0, 16'h801a, 16'h0000);
    cmp(type_rdata_out, 16'h0004);
    // Allocation at base 0x0010
    @(posedge core_clk_in);
    alloc_req_in <= 1'b1;
    alloc_base_in <= 16'h0010;
    @(posedge core_clk_in);
    alloc_req_in <= 1'b0;
    #1;
    cmp({alloc_ack_out, 8'h00, alloc_kind_out, alloc_words_out}, 16'h8028);
    // Back-to-back samples, one per channel, within and beyond the limits
    for (i = 0; i < 8; i++) begin
      @(posedge core_clk_in);
      sample_valid_in <= 1'b1;
      sample_ch_in <= 3'(i);
      sample_raw_in <= raw_tab[i];
    end
    @(posedge core_clk_in);
    sample_valid_in <= 1'b0;
    scan_start_in <= 1'b1;
    stall <= 1'b1;
    @(posedge core_clk_in);
    scan_start_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    #1;
    cmp({15'h0000, scan_busy_out}, 16'h0001);
    cmp(host_input_word_num_out, 16'h0010);
    // A start during the running scan must be ignored
    @(posedge core_clk_in);
    scan_start_in <= 1'b1;
    @(posedge core_clk_in);
    scan_start_in <= 1'b0;
    stall <= 1'b0;
    for (i = 0; i < 40 && host.got < 8; i++) @(posedge core_clk_in);
    repeat (6) @(posedge core_clk_in);
    #1;
    cmp(16'(host.got), 16'h0008);
    for (i = 0; i < 8; i++) begin
      cmp(host.nums[i], 16'h0010 + 16'(i));
      cmp(host.words[i], exp_word[i]);
    end
    cmp({14'h0000, ext24_err_out, status_ok_out}, 16'h0001);
    // Power up again without the external supply
    @(posedge core_clk_in);
    ext24_ok_in <= 1'b0;
    rst_in <= 1'b1;
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    // Look just after each edge, once the flag has settled
    for (i = 0; i < 20 && ext24_err_out !== 1'b1; i++) begin
      @(posedge core_clk_in);
      #1;
    end
    cmp({14'h0000, ext24_err_out, status_ok_out}, 16'h0002);
    type_acc(1'b0, 16'h801c, 16'h0000);
    cmp(type_rdata_out, `TYPE_BI_10V);
    stop_test;
  end
endmodule
